// *** testbench/evs_checker_sva.sv ***
// Checker for the exception vector selector: vector choice, debug
// qualification, deferral behind debug and NMI edge detection.
// Assumes it is bound onto exception_vector_select with one clock.
`timescale 1ns/1ns
`default_nettype none

module evs_checker (
    // Clock, reset and pipeline side
    input wire logic clk, rst_n, exc_accept, debug_return,
    input wire exc_vector_pkg::exc_class_t exc_class,
    // Mode and debug inputs
    input wire logic boot_vector_select, exception_level, probe_enable,
    input wire logic debug_single_step, software_debug_breakpoint_instr,
    input wire logic probe_break_request, real_time_debug, nmi_input_n,
    // Outputs
    input wire logic redirect_valid, redirect_debug, nmi_request,
    input wire logic debug_request, general_pending,
    input wire logic [exc_vector_pkg::VIRT_W-1:0] redirect_virt,
    input wire logic [exc_vector_pkg::PHYS_W-1:0] redirect_phys
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Qualified debug source, and a plain accept taken in idle
    logic dbg;
    logic acc;
    assign dbg = probe_break_request | (!real_time_debug &
        (debug_single_step | software_debug_breakpoint_instr));
    assign acc = exc_accept && !general_pending && !dbg;

    a_reset_vector: assert property (acc && exc_class < 3 |=> redirect_valid &&
        redirect_virt == exc_vector_pkg::VIRT_RESET_NMI &&
        redirect_phys == exc_vector_pkg::PHYS_RESET_NMI) else $error("reset vector wrong");
    a_refill_vector: assert property (acc && exc_class == 3 && !exception_level |=>
        redirect_virt == ($past(boot_vector_select) ? exc_vector_pkg::VIRT_REFILL_UNCACHED :
        exc_vector_pkg::VIRT_REFILL_CACHED)) else $error("refill vector wrong");
    a_wide_phys: assert property (acc && exc_class == 4 && !exception_level |=>
        redirect_phys == ($past(boot_vector_select) ? exc_vector_pkg::PHYS_WIDE_UNCACHED :
        exc_vector_pkg::PHYS_WIDE_CACHED)) else $error("wide refill phys wrong");
    a_common_vector: assert property (acc && exc_class > 2 && exc_class != 6 &&
        (exception_level || exc_class > 4) |=> !redirect_debug && redirect_virt ==
        ($past(boot_vector_select) ? exc_vector_pkg::VIRT_COMMON_UNCACHED :
        exc_vector_pkg::VIRT_COMMON_CACHED)) else $error("common vector wrong");
    a_debug_vector: assert property (exc_accept && !general_pending && dbg |=>
        redirect_valid && redirect_debug && redirect_phys == ($past(probe_enable) ?
        exc_vector_pkg::PHYS_DEBUG_PROBE : exc_vector_pkg::PHYS_DEBUG_NORMAL) &&
        redirect_virt[31:0] == ($past(probe_enable) ? 32'hFF20_0200 : 32'hBFC0_0400))
        else $error("debug vector wrong");
    a_kernel_seg: assert property (redirect_valid && !redirect_debug |->
        &redirect_virt[63:31] && !redirect_virt[30]) else $error("vector outside kernel");
    a_pulse_cause: assert property (redirect_valid |->
        $past(exc_accept) || $past(debug_return)) else $error("redirect without cause");
    a_debug_qual: assert property ($past(rst_n) |->
        debug_request == $past(dbg)) else $error("debug request wrong");
    a_defer_general: assert property (exc_accept && !general_pending && dbg &&
        exc_class != 6 |=> general_pending) else $error("general not parked");
    a_replay_general: assert property (general_pending && debug_return |=>
        redirect_valid && !redirect_debug && !general_pending) else $error("replay wrong");
    a_nmi_edge: assert property ($fell(nmi_input_n) |=>
        nmi_request ##1 !nmi_request) else $error("nmi request wrong");

    c_debug: cover property (redirect_valid && redirect_debug);
    c_replay: cover property (general_pending && debug_return);
    c_nmi: cover property (nmi_request);
endmodule : evs_checker

bind exception_vector_select evs_checker u_chk (.clk, .rst_n, .exc_accept, .debug_return,
    .exc_class, .boot_vector_select, .exception_level, .probe_enable, .debug_single_step,
    .software_debug_breakpoint_instr, .probe_break_request, .real_time_debug, .nmi_input_n,
    .redirect_valid, .redirect_debug, .nmi_request, .debug_request, .general_pending,
    .redirect_virt, .redirect_phys);

`default_nettype wire

// *** testbench/pipe_model.sv ***
// Pipeline partner: turns bench requests into one-cycle accepts and
// runs a debug handler that returns after a fixed number of cycles.
// Assumes go is held by the bench for exactly one cycle.
`timescale 1ns/1ns
`default_nettype none

module pipe_model #(parameter int HANDLER_CYCLES = 3) (
    // Clock, reset and bench request
    input wire logic clk, rst_n, go,
    input wire logic [2:0] cls,
    // Redirect seen from the selector
    input wire logic redirect_valid, redirect_debug,
    // Hand-off to the selector
    output logic exc_accept, debug_return,
    output var exc_vector_pkg::exc_class_t exc_class
);
    logic [3:0] cnt;

    // One-cycle accept with its class
    always_ff @(posedge clk) begin
        exc_accept <= rst_n & go;
        exc_class <= exc_vector_pkg::exc_class_t'(cls);
    end

    // Debug handler finishes and pulses the return
    always_ff @(posedge clk) begin
        debug_return <= rst_n && cnt == 4'h1;
        if (!rst_n) begin
            cnt <= 4'h0;
        end else if (redirect_valid && redirect_debug) begin
            cnt <= HANDLER_CYCLES[3:0];
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : pipe_model

`default_nettype wire

// *** testbench/tb.sv ***
// Bench for the exception vector selector: vector table, debug
// sources and deferral, refused debug class and NMI.
// Assumes pipe_model as partner and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk = 1'h0, rst_n = 1'h0, go = 1'h0, nmi_input_n = 1'h1;
    logic boot_vector_select = 1'h0, exception_level = 1'h0, error_level = 1'h0;
    logic interrupt_enable_bit = 1'h1, probe_enable = 1'h0, real_time_debug = 1'h0;
    logic debug_single_step = 1'h0, software_debug_breakpoint_instr = 1'h0;
    logic probe_break_request = 1'h0, d;
    logic [2:0] cls = 3'h0, s;
    logic exc_accept, debug_return, redirect_valid, redirect_debug;
    logic nmi_request, debug_request, general_pending;
    exc_vector_pkg::exc_class_t exc_class;
    logic [63:0] redirect_virt;
    logic [35:0] redirect_phys;
    logic [31:0] vb;
    logic [35:0] pb;
    int n_fail = 0, n_compared = 0, cycles = 0, b, c, i, k;

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    always #4 clk = ~clk;
    pipe_model pipe (.clk, .rst_n, .go, .cls, .redirect_valid, .redirect_debug,
        .exc_accept, .debug_return, .exc_class);
    exception_vector_select dut (.clk, .rst_n, .exc_accept, .exc_class, .debug_return,
        .boot_vector_select, .exception_level, .error_level, .interrupt_enable_bit,
        .probe_enable, .debug_single_step, .software_debug_breakpoint_instr,
        .probe_break_request, .real_time_debug, .nmi_input_n, .redirect_valid,
        .redirect_debug, .redirect_virt, .redirect_phys, .nmi_request, .debug_request,
        .general_pending);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [63:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    // One accepted exception and the redirect that answers it
    task automatic exc(input logic [2:0] cc, input logic bv, e, dd,
                       input logic [31:0] v, input logic [35:0] p);
        boot_vector_select = bv;
        exception_level = e;
        cls = cc;
        go = 1'h1;
        step;
        go = 1'h0;
        step;
        chk("valid", redirect_valid, 1'h1);
        chk("debug", redirect_debug, dd);
        chk("virt", redirect_virt, {32'hFFFF_FFFF, v});
        chk("phys", redirect_phys, p);
    endtask : exc

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            give_verdict;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'h1;
        step;
        for (b = 0; b < 2; b++) begin
            vb = b[0] ? 32'hBFC0_0200 : 32'h8000_0000;
            pb = b[0] ? 36'h0_1FC0_0200 : 36'h0_0000_0000;
            for (c = 0; c < 3; c++) begin
                exc(c[2:0], b[0], b[0], 1'h0, 32'hBFC0_0000, 36'h0_1FC0_0000);
            end
            exc(3'h3, b[0], 1'h0, 1'h0, vb, pb);
            exc(3'h4, b[0], 1'h0, 1'h0, vb + 32'h80, pb + 36'h80);
            exc(3'h5, b[0], 1'h0, 1'h0, vb + 32'h180, pb + 36'h180);
            for (c = 3; c < 8; c++) begin
                if (c != 6) begin
                    exc(c[2:0], b[0], 1'h1, 1'h0, vb + 32'h180, pb + 36'h180);
                end
            end
        end
        for (i = 0; i < 6; i++) begin
            s = 3'h1 << (i % 3);
            {probe_break_request, debug_single_step, software_debug_breakpoint_instr} = s;
            real_time_debug = i > 2;
            probe_enable = i[0];
            d = i < 3 || s == 3'h4;
            step;
            chk("dreq", debug_request, d);
            if (d) begin
                exc(3'h5, 1'h0, 1'h0, 1'h1, probe_enable ? 32'hFF20_0200 : 32'hBFC0_0400,
                    probe_enable ? 36'hF_FF20_0200 : 36'h0_1FC0_0400);
                step;
                chk("pend", general_pending, 1'h1);
                for (k = 0; k < 8 && redirect_valid !== 1'h1; k++) step;
                chk("rvalid", redirect_valid, 1'h1);
                chk("replay", redirect_virt, 64'hFFFF_FFFF_8000_0180);
                chk("rdbg", redirect_debug, 1'h0);
                chk("pend", general_pending, 1'h0);
            end else begin
                exc(3'h5, 1'h0, 1'h0, 1'h0, 32'h8000_0180, 36'h0_0000_0180);
            end
        end
        // Debug class with the probe source still up: debug vector, nothing parked
        exc(3'h6, 1'h0, 1'h0, 1'h1, 32'hFF20_0200, 36'hF_FF20_0200);
        chk("pend", general_pending, 1'h0);
        {probe_break_request, debug_single_step, software_debug_breakpoint_instr} = 3'h0;
        cls = 3'h6;
        go = 1'h1;
        step;
        go = 1'h0;
        step;
        chk("refused", redirect_valid, 1'h0);
        error_level = 1'h1;
        interrupt_enable_bit = 1'h0;
        exception_level = 1'h1;
        nmi_input_n = 1'h0;
        step;
        chk("nmi", nmi_request, 1'h1);
        step;
        chk("nmi", nmi_request, 1'h0);
        // Mid-run reset with the pin held low: no request at release
        rst_n = 1'h0;
        step;
        step;
        chk("rvirt", redirect_virt, 64'hFFFF_FFFF_BFC0_0000);
        chk("rphys", redirect_phys, 36'h0_1FC0_0000);
        rst_n = 1'h1;
        step;
        chk("nmi", nmi_request, 1'h0);
        step;
        chk("nmi", nmi_request, 1'h0);
        chk("pend", general_pending, 1'h0);
        chk("valid", redirect_valid, 1'h0);
        give_verdict;
    end
endmodule : tb

`default_nettype wire

// *** verilog/exc_vector_pkg.sv ***
// Package for the exception vector selector: exception classes,
// vector addresses and widths.
// Assumes the pipeline presents exception classes with these codes.
package exc_vector_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int VIRT_W = 64;
    localparam int PHYS_W = 36;

    // ------------------------------------------------------------
    // Exception classes (no cache error class exists)
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EXC_COLD_RESET,
        EXC_SOFT_RESET,
        EXC_NMI,
        EXC_TLB_REFILL,
        EXC_WIDE_TLB_REFILL,
        EXC_COMMON,
        EXC_DEBUG
    } exc_class_t;

    // ------------------------------------------------------------
    // Virtual vectors
    // ------------------------------------------------------------
    localparam logic [VIRT_W-1:0] VIRT_RESET_NMI = 64'hFFFF_FFFF_BFC0_0000;
    localparam logic [VIRT_W-1:0] VIRT_REFILL_CACHED = 64'hFFFF_FFFF_8000_0000;
    localparam logic [VIRT_W-1:0] VIRT_WIDE_CACHED = 64'hFFFF_FFFF_8000_0080;
    localparam logic [VIRT_W-1:0] VIRT_COMMON_CACHED = 64'hFFFF_FFFF_8000_0180;
    localparam logic [VIRT_W-1:0] VIRT_REFILL_UNCACHED = 64'hFFFF_FFFF_BFC0_0200;
    localparam logic [VIRT_W-1:0] VIRT_WIDE_UNCACHED = 64'hFFFF_FFFF_BFC0_0280;
    localparam logic [VIRT_W-1:0] VIRT_COMMON_UNCACHED = 64'hFFFF_FFFF_BFC0_0380;
    localparam logic [VIRT_W-1:0] VIRT_DEBUG_NORMAL = 64'hFFFF_FFFF_BFC0_0400;
    localparam logic [VIRT_W-1:0] VIRT_DEBUG_PROBE = 64'hFFFF_FFFF_FF20_0200;

    // ------------------------------------------------------------
    // Physical vectors
    // ------------------------------------------------------------
    localparam logic [PHYS_W-1:0] PHYS_RESET_NMI = 36'h0_1FC0_0000;
    localparam logic [PHYS_W-1:0] PHYS_REFILL_CACHED = 36'h0_0000_0000;
    localparam logic [PHYS_W-1:0] PHYS_WIDE_CACHED = 36'h0_0000_0080;
    localparam logic [PHYS_W-1:0] PHYS_COMMON_CACHED = 36'h0_0000_0180;
    localparam logic [PHYS_W-1:0] PHYS_REFILL_UNCACHED = 36'h0_1FC0_0200;
    localparam logic [PHYS_W-1:0] PHYS_WIDE_UNCACHED = 36'h0_1FC0_0280;
    localparam logic [PHYS_W-1:0] PHYS_COMMON_UNCACHED = 36'h0_1FC0_0380;
    localparam logic [PHYS_W-1:0] PHYS_DEBUG_NORMAL = 36'h0_1FC0_0400;
    localparam logic [PHYS_W-1:0] PHYS_DEBUG_PROBE = 36'hF_FF20_0200;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic NMI_LEVEL_RESET = 1'h1;

endpackage : exc_vector_pkg

// *** verilog/exception_vector_select.sv ***
// Exception vector selector: chooses the redirect address for each
// accepted exception while none is deferred, except a debug class with no qualified debug
// source, raises debug and NMI requests, and defers a general
// exception behind a debug exception on the same instruction.
// Assumes a single clock, synchronous inputs and a pipeline that
// pulses exc_accept for one cycle per accepted exception.
//
// Functional notes
// - Reset and NMI always use uncached boot vector
// - Boot select picks cached or uncached segment
// - Cached refill, wide refill, common virtual vectors
// - Uncached refill, wide refill, common virtual vectors
// - Physical vectors follow the same two sets
// - No cache error exception class exists
// - Debug virtual vector chosen by probe enable
// - Debug physical vector chosen by probe enable
// - Debug raised only by three sources
// - Real-time debug leaves only probe break
// - Non-debug vectors stay in kernel segments
// - NMI on falling edge, ignoring mask bits
// - Debug taken first, general exception afterwards
`timescale 1ns/1ns
`default_nettype none

module exception_vector_select (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pipeline exception hand-off
    input wire logic exc_accept,
    input wire exc_vector_pkg::exc_class_t exc_class,
    input wire logic debug_return,
    // Mode bits
    input wire logic boot_vector_select,
    input wire logic exception_level,
    input wire logic error_level,
    input wire logic interrupt_enable_bit,
    input wire logic probe_enable,
    // Debug sources
    input wire logic debug_single_step,
    input wire logic software_debug_breakpoint_instr,
    input wire logic probe_break_request,
    input wire logic real_time_debug,
    // Interrupt pin
    input wire logic nmi_input_n,
    // Redirect to fetch
    output logic redirect_valid,
    output logic redirect_debug,
    output logic [exc_vector_pkg::VIRT_W-1:0] redirect_virt,
    output logic [exc_vector_pkg::PHYS_W-1:0] redirect_phys,
    // Requests to the pipeline
    output logic nmi_request,
    output logic debug_request,
    output logic general_pending
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_DEFERRED
    } defer_state_t;

    defer_state_t state;
    defer_state_t next_state;
    exc_vector_pkg::exc_class_t held_class;
    exc_vector_pkg::exc_class_t lookup_class;
    logic nmi_level;
    logic debug_raise;
    logic take_redirect;
    logic take_debug;
    logic [exc_vector_pkg::VIRT_W-1:0] chosen_virt;
    logic [exc_vector_pkg::PHYS_W-1:0] chosen_phys;
    logic mask_bits_unused;

    // Status mask bits have no say over NMI
    assign mask_bits_unused = exception_level & error_level & interrupt_enable_bit;

    // ------------------------------------------------------------
    // Debug source qualification
    // ------------------------------------------------------------

    // Probe break always counts; the other two only outside real-time debug
    assign debug_raise = probe_break_request
                       | (~real_time_debug
                          & (debug_single_step | software_debug_breakpoint_instr));

    // ------------------------------------------------------------
    // Selection of the class fed to the vector table
    // ------------------------------------------------------------

    // A deferred general exception is replayed when debug returns
    always_comb begin
        take_redirect = 1'b0;
        take_debug = 1'b0;
        next_state = state;
        lookup_class = exc_class;
        case (state)
            ST_IDLE: begin
                if (exc_accept && debug_raise) begin
                    take_redirect = 1'b1;
                    take_debug = 1'b1;
                    lookup_class = exc_vector_pkg::EXC_DEBUG;
                    if (exc_class != exc_vector_pkg::EXC_DEBUG) begin
                        next_state = ST_DEFERRED;
                    end
                end else if (exc_accept && exc_class != exc_vector_pkg::EXC_DEBUG) begin
                    take_redirect = 1'b1;
                end
            end
            ST_DEFERRED: begin
                lookup_class = held_class;
                if (debug_return) begin
                    take_redirect = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    vector_lookup u_vector_lookup (
        .exc_class(lookup_class),
        .boot_vector_select(boot_vector_select),
        .exception_level(exception_level),
        .probe_enable(probe_enable),
        .vector_virt(chosen_virt),
        .vector_phys(chosen_phys)
    );

    // ------------------------------------------------------------
    // Deferral state
    // ------------------------------------------------------------

    // Tracks a general exception parked behind a debug exception
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Captures the general class when debug wins the instruction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            held_class <= exc_vector_pkg::EXC_COMMON;
        end else if (state == ST_IDLE && next_state == ST_DEFERRED) begin
            held_class <= exc_class;
        end
    end

    // Pending flag mirrors the deferral state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            general_pending <= 1'b0;
        end else begin
            general_pending <= (next_state == ST_DEFERRED);
        end
    end

    // ------------------------------------------------------------
    // Redirect outputs
    // ------------------------------------------------------------

    // Vector chosen in the accept cycle, presented to fetch next cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            redirect_valid <= 1'b0;
            redirect_debug <= 1'b0;
        end else begin
            redirect_valid <= take_redirect;
            redirect_debug <= take_debug;
        end
    end

    // Address registers hold the last chosen vector
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            redirect_virt <= exc_vector_pkg::VIRT_RESET_NMI;
            redirect_phys <= exc_vector_pkg::PHYS_RESET_NMI;
        end else if (take_redirect) begin
            redirect_virt <= chosen_virt;
            redirect_phys <= chosen_phys;
        end
    end

    // ------------------------------------------------------------
    // Debug request
    // ------------------------------------------------------------

    // Level request to the pipeline while a qualified source is active
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            debug_request <= 1'b0;
        end else begin
            debug_request <= debug_raise;
        end
    end

    // ------------------------------------------------------------
    // NMI edge detection
    // ------------------------------------------------------------

    // Previous pin level, tracked through reset: a pin held low across
    // reset must not look like a fresh falling edge at release
    always_ff @(posedge clk) begin
        nmi_level <= nmi_input_n;
    end

    // One-cycle request on a high-to-low transition, unmasked
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmi_request <= 1'b0;
        end else begin
            nmi_request <= nmi_level & ~nmi_input_n;
        end
    end

endmodule : exception_vector_select

`default_nettype wire

// *** verilog/vector_lookup.sv ***
// Combinational vector table: maps an exception class and the mode
// bits onto virtual and physical vector addresses.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`default_nettype none

module vector_lookup (
    // Selection
    input wire exc_vector_pkg::exc_class_t exc_class,
    input wire logic boot_vector_select,
    input wire logic exception_level,
    input wire logic probe_enable,
    // Result
    output logic [exc_vector_pkg::VIRT_W-1:0] vector_virt,
    output logic [exc_vector_pkg::PHYS_W-1:0] vector_phys
);

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------

    // Refills with exception level set fall back to the common vector
    always_comb begin
        case (exc_class)
            exc_vector_pkg::EXC_COLD_RESET,
            exc_vector_pkg::EXC_SOFT_RESET,
            exc_vector_pkg::EXC_NMI: begin
                vector_virt = exc_vector_pkg::VIRT_RESET_NMI;
                vector_phys = exc_vector_pkg::PHYS_RESET_NMI;
            end
            exc_vector_pkg::EXC_TLB_REFILL: begin
                if (exception_level) begin
                    vector_virt = boot_vector_select ? exc_vector_pkg::VIRT_COMMON_UNCACHED
                                                     : exc_vector_pkg::VIRT_COMMON_CACHED;
                    vector_phys = boot_vector_select ? exc_vector_pkg::PHYS_COMMON_UNCACHED
                                                     : exc_vector_pkg::PHYS_COMMON_CACHED;
                end else begin
                    vector_virt = boot_vector_select ? exc_vector_pkg::VIRT_REFILL_UNCACHED
                                                     : exc_vector_pkg::VIRT_REFILL_CACHED;
                    vector_phys = boot_vector_select ? exc_vector_pkg::PHYS_REFILL_UNCACHED
                                                     : exc_vector_pkg::PHYS_REFILL_CACHED;
                end
            end
            exc_vector_pkg::EXC_WIDE_TLB_REFILL: begin
                if (exception_level) begin
                    vector_virt = boot_vector_select ? exc_vector_pkg::VIRT_COMMON_UNCACHED
                                                     : exc_vector_pkg::VIRT_COMMON_CACHED;
                    vector_phys = boot_vector_select ? exc_vector_pkg::PHYS_COMMON_UNCACHED
                                                     : exc_vector_pkg::PHYS_COMMON_CACHED;
                end else begin
                    vector_virt = boot_vector_select ? exc_vector_pkg::VIRT_WIDE_UNCACHED
                                                     : exc_vector_pkg::VIRT_WIDE_CACHED;
                    vector_phys = boot_vector_select ? exc_vector_pkg::PHYS_WIDE_UNCACHED
                                                     : exc_vector_pkg::PHYS_WIDE_CACHED;
                end
            end
            exc_vector_pkg::EXC_DEBUG: begin
                vector_virt = probe_enable ? exc_vector_pkg::VIRT_DEBUG_PROBE
                                           : exc_vector_pkg::VIRT_DEBUG_NORMAL;
                vector_phys = probe_enable ? exc_vector_pkg::PHYS_DEBUG_PROBE
                                           : exc_vector_pkg::PHYS_DEBUG_NORMAL;
            end
            default: begin
                // Common vector, segment chosen by boot vector select
                vector_virt = boot_vector_select ? exc_vector_pkg::VIRT_COMMON_UNCACHED
                                                 : exc_vector_pkg::VIRT_COMMON_CACHED;
                vector_phys = boot_vector_select ? exc_vector_pkg::PHYS_COMMON_UNCACHED
                                                 : exc_vector_pkg::PHYS_COMMON_CACHED;
            end
        endcase
    end

endmodule : vector_lookup

`default_nettype wire
